// *** hdl/adc_hw_trigger_sequencer.sv ***
// Hardware-triggered conversion sequencer with classic Wishbone registers
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps

// Operation
// - No-wait power-on enters conversion standby
// - No-wait start only arms trigger standby
// - Scan trigger converts four slots from zero
// - Each conversion stores result, pulses irq
// - Sequential scan wraps without new trigger
// - One-shot scan keeps start, returns standby
// - Scan trigger or start rewrite restarts
// - Scan channel write restarts on new first
// - Select channel write converts new input
// - Select trigger or start rewrite restarts
// - No-wait start clear aborts, stays powered
// - Power clear powers down; start ignored
// - No-wait trigger ignored while start clear
// - Wait-mode power-on enters trigger standby
// - Wait trigger starts conversion, sets start
// - Wait sequential select repeats immediately
// - Wait one-shot clears start, powers down
// - Wait start clear aborts to powered-down standby
module adc_hw_trigger_sequencer (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [3:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Trigger source
    input  wire logic              hw_trigger_i,
    // Conversion core
    input  wire adc_pkg::conv_rsp_s conv_rsp_i,
    output adc_pkg::conv_req_s     conv_req_o,
    output logic                   analog_power_o,
    output logic                   conversion_end_irq_o
);

    adc_pkg::conv_state_e           state_q, state_d;
    logic                           converter_power_on_q;
    logic                           conversion_start_q, start_d;
    logic                           wait_mode_q, wait_d;
    logic                           scan_q;
    logic                           one_shot_q;
    logic [adc_pkg::CH_W-1:0]       chsel_q, chsel_d;
    logic [adc_pkg::RES_W-1:0]      result_q;
    logic [adc_pkg::SLOT_W-1:0]     slot_q, slot_d;
    logic                           go, abort, store;
    logic                           access, wr, wr_mode, wr_chsel;
    logic                           new_power, new_start, start_wr1, start_wr0;
    logic                           quiet;
    logic [31:0]                    rdata;

    // Channel of a scan slot; select modes ignore the slot
    function automatic logic [adc_pkg::CH_W-1:0] ch_of(
        input logic [adc_pkg::CH_W-1:0]   base,
        input logic [adc_pkg::SLOT_W-1:0] slot,
        input logic                       scan
    );
        logic [adc_pkg::CH_W-1:0] wide;
        wide = {{(adc_pkg::CH_W-adc_pkg::SLOT_W){1'b0}}, slot};
        return scan ? base + wide : base;
    endfunction : ch_of

    // Bus decode; a write lands on the edge the master sees ack
    assign access    = wb_cyc_i && wb_stb_i && ce_i;
    assign wr        = access && wb_ack_o && wb_we_i;
    assign wr_mode   = wr && wb_sel_i[0] && (wb_adr_i == adc_pkg::OFS_MODE);
    assign wr_chsel  = wr && wb_sel_i[0] && (wb_adr_i == adc_pkg::OFS_CHSEL);
    assign new_power = wb_dat_i[adc_pkg::BIT_POWER];
    assign new_start = wb_dat_i[adc_pkg::BIT_START];
    assign start_wr1 = wr_mode && new_start && converter_power_on_q;
    assign start_wr0 = wr_mode && !new_start;
    assign chsel_d   = wr_chsel ? wb_dat_i[adc_pkg::CH_W-1:0] : chsel_q;
    assign quiet     = !wr_mode && !wr_chsel && !hw_trigger_i;
    assign wait_d    = wr_mode ? wb_dat_i[adc_pkg::BIT_WAIT] : wait_mode_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        case (wb_adr_i)
            adc_pkg::OFS_MODE: begin
                rdata[adc_pkg::BIT_POWER]   = converter_power_on_q;
                rdata[adc_pkg::BIT_START]   = conversion_start_q;
                rdata[adc_pkg::BIT_WAIT]    = wait_mode_q;
                rdata[adc_pkg::BIT_SCAN]    = scan_q;
                rdata[adc_pkg::BIT_ONESHOT] = one_shot_q;
            end
            adc_pkg::OFS_CHSEL:  rdata[adc_pkg::CH_W-1:0] = chsel_q;
            adc_pkg::OFS_RESULT: rdata[adc_pkg::RES_W-1:0] = result_q;
            adc_pkg::OFS_STATUS: begin
                rdata[adc_pkg::STS_BUSY] = (state_q == adc_pkg::ST_CONV);
                rdata[adc_pkg::STS_PWR]  = analog_power_o;
                rdata[adc_pkg::STS_SLOT +: adc_pkg::SLOT_W] = slot_q;
                rdata[adc_pkg::STS_CH +: adc_pkg::CH_W] = ch_of(chsel_q, slot_q, scan_q);
            end
            default: rdata = 32'h0000_0000;
        endcase
    end

    // Read data stands while ack is high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i && access && !wb_ack_o) begin
            wb_dat_o <= rdata;
        end
    end

    // Mode bits; changing them outside power-down is not meant to be done
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            converter_power_on_q <= adc_pkg::MODE_BIT_RST;
            wait_mode_q          <= adc_pkg::MODE_BIT_RST;
            scan_q               <= adc_pkg::MODE_BIT_RST;
            one_shot_q           <= adc_pkg::MODE_BIT_RST;
        end else if (wr_mode) begin
            converter_power_on_q <= new_power;
            wait_mode_q          <= wb_dat_i[adc_pkg::BIT_WAIT];
            scan_q               <= wb_dat_i[adc_pkg::BIT_SCAN];
            one_shot_q           <= wb_dat_i[adc_pkg::BIT_ONESHOT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chsel_q <= adc_pkg::CHSEL_RST;
        end else if (ce_i) begin
            chsel_q <= chsel_d;
        end
    end

    // Sequencer; abort and restart take priority over a finishing result
    always_comb begin
        state_d = state_q;
        start_d = conversion_start_q;
        slot_d  = slot_q;
        go      = 1'b0;
        abort   = 1'b0;
        store   = 1'b0;
        if (wr_mode && !new_power && state_q != adc_pkg::ST_OFF) begin
            state_d = adc_pkg::ST_OFF;
            start_d = 1'b0;
            abort   = (state_q == adc_pkg::ST_CONV);
        end else begin
            case (state_q)
                adc_pkg::ST_OFF: begin
                    if (wr_mode && new_power) begin
                        state_d = wait_d ? adc_pkg::ST_TRIG_WAIT
                                              : adc_pkg::ST_STANDBY;
                    end
                end
                adc_pkg::ST_STANDBY: begin
                    if (start_wr1) begin
                        state_d = adc_pkg::ST_TRIG_WAIT;
                        start_d = 1'b1;
                    end else if (start_wr0) begin
                        start_d = 1'b0;
                    end
                end
                adc_pkg::ST_TRIG_WAIT: begin
                    if (start_wr0) begin
                        start_d = 1'b0;
                        if (!wait_mode_q) begin
                            state_d = adc_pkg::ST_STANDBY;
                        end
                    end else if (wait_mode_q && hw_trigger_i) begin
                        go      = 1'b1;
                        start_d = 1'b1;
                        slot_d  = 2'h0;
                    end else if (!wait_mode_q && hw_trigger_i && conversion_start_q) begin
                        go     = 1'b1;
                        slot_d = 2'h0;
                    end else if (start_wr1) begin
                        start_d = 1'b1;
                    end
                end
                adc_pkg::ST_CONV: begin
                    if (start_wr0) begin
                        abort   = 1'b1;
                        start_d = 1'b0;
                        state_d = wait_mode_q ? adc_pkg::ST_TRIG_WAIT
                                              : adc_pkg::ST_STANDBY;
                    end else if (hw_trigger_i || start_wr1 || wr_chsel) begin
                        go     = 1'b1;
                        slot_d = 2'h0;
                    end else if (conv_rsp_i.done) begin
                        store = 1'b1;
                        if (scan_q && slot_q != adc_pkg::SLOT_LAST) begin
                            go     = 1'b1;
                            slot_d = slot_q + 2'h1;
                        end else if (!one_shot_q) begin
                            go     = 1'b1;
                            slot_d = 2'h0;
                        end else if (wait_mode_q) begin
                            state_d = adc_pkg::ST_TRIG_WAIT;
                            start_d = 1'b0;
                        end else begin
                            state_d = adc_pkg::ST_STANDBY;
                        end
                    end
                end
                default: state_d = adc_pkg::ST_OFF;
            endcase
        end
        if (go) begin
            state_d = adc_pkg::ST_CONV;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q            <= adc_pkg::ST_OFF;
            conversion_start_q <= adc_pkg::MODE_BIT_RST;
            slot_q             <= 2'h0;
        end else if (ce_i) begin
            state_q            <= state_d;
            conversion_start_q <= start_d;
            slot_q             <= slot_d;
        end
    end

    // A new start to the core cancels whatever it was converting
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_req_o <= '0;
        end else if (ce_i) begin
            conv_req_o.start   <= go;
            conv_req_o.abort   <= abort;
            conv_req_o.channel <= go ? ch_of(chsel_d, slot_d, scan_q) : conv_req_o.channel;
        end
    end

    // Wait mode keeps the converter unpowered between conversions
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            analog_power_o <= 1'b0;
        end else if (ce_i) begin
            analog_power_o <= (state_d != adc_pkg::ST_OFF) &&
                              (!wait_d || state_d == adc_pkg::ST_CONV);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_q             <= adc_pkg::RESULT_RST;
            conversion_end_irq_o <= 1'b0;
        end else if (ce_i) begin
            conversion_end_irq_o <= store;
            if (store) begin
                result_q <= conv_rsp_i.data;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_nowait_power_on;
        ce_i && state_q == adc_pkg::ST_OFF && wr_mode && new_power && !wb_dat_i[adc_pkg::BIT_WAIT]
            |=> state_q == adc_pkg::ST_STANDBY && analog_power_o;
    endproperty
    a_nowait_power_on: assert property (p_nowait_power_on) else $error("power-on missed standby");
    property p_wait_power_on;
        ce_i && state_q == adc_pkg::ST_OFF && wr_mode && new_power && wb_dat_i[adc_pkg::BIT_WAIT]
            |=> state_q == adc_pkg::ST_TRIG_WAIT && !analog_power_o;
    endproperty
    a_wait_power_on: assert property (p_wait_power_on) else $error("wait power-on wrong");

    property p_start_arms_only;
        ce_i && state_q == adc_pkg::ST_STANDBY && start_wr1 && new_power && !wait_mode_q
            |=> state_q == adc_pkg::ST_TRIG_WAIT && !conv_req_o.start;
    endproperty
    a_start_arms_only: assert property (p_start_arms_only) else $error("start began conversion");

    property p_scan_first_slot;
        ce_i && state_q == adc_pkg::ST_TRIG_WAIT && !wait_mode_q && scan_q && conversion_start_q
            && hw_trigger_i && !wr_mode && !wr_chsel
            |=> state_q == adc_pkg::ST_CONV && slot_q == 2'h0 && conv_req_o.start
                && conv_req_o.channel == $past(chsel_q);
    endproperty
    a_scan_first_slot: assert property (p_scan_first_slot) else $error("scan start wrong");

    property p_result_irq;
        ce_i && state_q == adc_pkg::ST_CONV && conv_rsp_i.done && quiet
            |=> conversion_end_irq_o && result_q == $past(conv_rsp_i.data) ##1 !conversion_end_irq_o
                || !$past(ce_i);
    endproperty
    a_result_irq: assert property (p_result_irq) else $error("result or irq wrong");

    property p_scan_wrap;
        ce_i && state_q == adc_pkg::ST_CONV && conv_rsp_i.done && quiet && scan_q && !one_shot_q
            && slot_q == adc_pkg::SLOT_LAST
            |=> state_q == adc_pkg::ST_CONV && slot_q == 2'h0 && conv_req_o.start;
    endproperty
    a_scan_wrap: assert property (p_scan_wrap) else $error("scan did not wrap");

    property p_oneshot_scan_end;
        ce_i && state_q == adc_pkg::ST_CONV && conv_rsp_i.done && quiet && scan_q && one_shot_q
            && !wait_mode_q && slot_q == adc_pkg::SLOT_LAST
            |=> state_q == adc_pkg::ST_STANDBY && conversion_start_q && analog_power_o;
    endproperty
    a_oneshot_scan_end: assert property (p_oneshot_scan_end) else $error("one-shot end wrong");

    property p_trigger_restart;
        ce_i && state_q == adc_pkg::ST_CONV && hw_trigger_i && !wr_mode
            |=> state_q == adc_pkg::ST_CONV && slot_q == 2'h0 && conv_req_o.start;
    endproperty
    a_trigger_restart: assert property (p_trigger_restart) else $error("no restart");

    property p_chsel_restart;
        ce_i && state_q == adc_pkg::ST_CONV && wr_chsel
            |=> conv_req_o.start && slot_q == 2'h0
                && conv_req_o.channel == $past(wb_dat_i[adc_pkg::CH_W-1:0]);
    endproperty
    a_chsel_restart: assert property (p_chsel_restart) else $error("bad channel restart");

    property p_nowait_stop;
        ce_i && state_q == adc_pkg::ST_CONV && !wait_mode_q && start_wr0 && new_power
            |=> state_q == adc_pkg::ST_STANDBY && analog_power_o && conv_req_o.abort;
    endproperty
    a_nowait_stop: assert property (p_nowait_stop) else $error("stop wrong");

    property p_start_ignored_off;
        ce_i && !converter_power_on_q && wr_mode && new_start |=> !conversion_start_q;
    endproperty
    a_start_ignored_off: assert property (p_start_ignored_off) else $error("start taken");

    property p_trigger_ignored;
        ce_i && !wait_mode_q && !conversion_start_q && hw_trigger_i && !wr_mode
            && state_q != adc_pkg::ST_CONV |=> state_q != adc_pkg::ST_CONV;
    endproperty
    a_trigger_ignored: assert property (p_trigger_ignored) else $error("trigger not ignored");

    property p_wait_trigger;
        ce_i && wait_mode_q && state_q == adc_pkg::ST_TRIG_WAIT && hw_trigger_i && !wr_mode
            |=> state_q == adc_pkg::ST_CONV && conversion_start_q && analog_power_o;
    endproperty
    a_wait_trigger: assert property (p_wait_trigger) else $error("wait trigger wrong");

    property p_wait_oneshot_end;
        ce_i && state_q == adc_pkg::ST_CONV && conv_rsp_i.done && quiet && wait_mode_q
            && one_shot_q && (!scan_q || slot_q == adc_pkg::SLOT_LAST)
            |=> state_q == adc_pkg::ST_TRIG_WAIT && !conversion_start_q && !analog_power_o;
    endproperty
    a_wait_oneshot_end: assert property (p_wait_oneshot_end) else $error("wait end wrong");

    property p_abandon_silent;
        ce_i && state_q == adc_pkg::ST_CONV && conv_rsp_i.done && (hw_trigger_i || wr_chsel)
            |=> !conversion_end_irq_o && result_q == $past(result_q);
    endproperty
    a_abandon_silent: assert property (p_abandon_silent) else $error("abandoned result kept");

endmodule : adc_hw_trigger_sequencer

// *** hdl/adc_pkg.sv ***
// Constants, register map and carrier types for the trigger sequencer
package adc_pkg;

    // Register byte offsets
    localparam logic [3:0] OFS_MODE   = 4'h0;
    localparam logic [3:0] OFS_CHSEL  = 4'h4;
    localparam logic [3:0] OFS_RESULT = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;

    // Mode register bit positions
    localparam int BIT_POWER   = 0;
    localparam int BIT_START   = 1;
    localparam int BIT_WAIT    = 2;
    localparam int BIT_SCAN    = 3;
    localparam int BIT_ONESHOT = 4;

    // Status register bit positions
    localparam int STS_BUSY    = 0;
    localparam int STS_PWR     = 1;
    localparam int STS_SLOT    = 2;
    localparam int STS_CH      = 4;

    // Widths
    localparam int CH_W        = 3;
    localparam int RES_W       = 10;
    localparam int SLOT_W      = 2;
    localparam logic [1:0] SLOT_LAST = 2'h3;

    // Reset values
    localparam logic             MODE_BIT_RST = 1'h0;
    localparam logic [CH_W-1:0]  CHSEL_RST    = 3'h0;
    localparam logic [RES_W-1:0] RESULT_RST   = 10'h000;

    // Software stabilisation wait after power-on, for the bench
    localparam int CLK_PERIOD_NS     = 4;
    localparam int STAB_WAIT_NS      = 1000;
    localparam int STAB_WAIT_CYCLES  = (STAB_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_STANDBY,
        ST_TRIG_WAIT,
        ST_CONV
    } conv_state_e;

    typedef struct packed {
        logic            start;
        logic            abort;
        logic [CH_W-1:0] channel;
    } conv_req_s;

    typedef struct packed {
        logic             done;
        logic [RES_W-1:0] data;
    } conv_rsp_s;

endpackage : adc_pkg

// *** verification/adc_conv_core_model.sv ***
// Behavioural model of the conversion core behind the sequencer
`timescale 1ns/1ps
module adc_conv_core_model (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // Request side and latency control
    input  wire adc_pkg::conv_req_s conv_req_i,
    input  wire logic [7:0]         lat_i,
    // Result side
    output adc_pkg::conv_rsp_s      conv_rsp_o
);
    logic [7:0]  cnt_q;
    logic        busy_q;
    logic [2:0]  ch_q;
    logic [9:0]  last_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q     <= 1'b0;
            cnt_q      <= 8'h00;
            ch_q       <= 3'h0;
            last_q     <= 10'h000;
            conv_rsp_o <= '0;
        end else begin
            conv_rsp_o.done <= 1'b0;
            // Data is only valid with done; scramble it otherwise
            conv_rsp_o.data <= ~last_q;
            if (conv_req_i.start) begin
                busy_q <= 1'b1;
                cnt_q  <= lat_i;
                ch_q   <= conv_req_i.channel;
            end else if (conv_req_i.abort) begin
                busy_q <= 1'b0;
            end else if (busy_q) begin
                if (cnt_q == 8'h00) begin
                    busy_q          <= 1'b0;
                    conv_rsp_o.done <= 1'b1;
                    conv_rsp_o.data <= {4'hA, 3'h0, ch_q};
                    last_q          <= {4'hA, 3'h0, ch_q};
                end else begin
                    cnt_q <= cnt_q - 8'h01;
                end
            end
        end
    end
endmodule : adc_conv_core_model

// *** verification/adc_hw_trigger_sequencer_tb_top.sv ***
// Self-checking bench for the hardware trigger sequencer
`timescale 1ns/1ps
module adc_hw_trigger_sequencer_tb_top;
    localparam logic [31:0] PW = 32'h1 << adc_pkg::BIT_POWER;
    localparam logic [31:0] ST = 32'h1 << adc_pkg::BIT_START;
    localparam logic [31:0] WT = 32'h1 << adc_pkg::BIT_WAIT;
    localparam logic [31:0] SC = 32'h1 << adc_pkg::BIT_SCAN;
    localparam logic [31:0] OS = 32'h1 << adc_pkg::BIT_ONESHOT;
    logic               clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic               cyc = 1'b0, stb = 1'b0, we = 1'b0, trig = 1'b0;
    logic [3:0]         adr = 4'h0, sel = 4'h0;
    logic [31:0]        wdat = 32'h0, rd, dat_o, seed = 32'h298E;
    logic [7:0]         lat = 8'h0C;
    logic               ack, pwr, irq;
    adc_pkg::conv_req_s req;
    adc_pkg::conv_rsp_s rsp;
    logic [2:0]         starts[$];
    logic [2:0]         ch, c;
    int                 fails = 0, checks_done = 0, nirq = 0, n0;

    always #2 clk_i = ~clk_i;

    adc_hw_trigger_sequencer i_adc_hw_trigger_sequencer (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .hw_trigger_i(trig), .conv_rsp_i(rsp), .conv_req_o(req),
        .analog_power_o(pwr), .conversion_end_irq_o(irq));
    adc_conv_core_model i_adc_conv_core_model (
        .clk_i(clk_i), .rst_i(rst_i), .conv_req_i(req), .lat_i(lat), .conv_rsp_o(rsp));

    // Latency stays above the bus turnaround so mid-conversion writes land in time
    always @(posedge clk_i) begin
        if (!rst_i && req.start === 1'b1) starts.push_back(req.channel);
        if (!rst_i && irq === 1'b1) nirq++;
        lat <= 8'h0C + {3'h0, seed[4:0]};
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [31:0] exp_res(input logic [2:0] k);
        return {22'h0, 4'hA, 3'h0, k};
    endfunction : exp_res

    task finish_test;
        if (fails == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        sel  <= 4'hF;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
        if (n >= 50) begin
            fails++;
            finish_test();
        end
    endtask : wb
    task pulse;
        @(posedge clk_i);
        trig <= 1'b1;
        @(posedge clk_i);
        trig <= 1'b0;
    endtask : pulse
    task get_start(output logic [2:0] k);
        int n;
        n = 0;
        while (starts.size() == 0 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        if (starts.size() == 0) begin
            fails++;
            finish_test();
        end else k = starts.pop_front();
    endtask : get_start
    task quiet(input int n);
        starts.delete();
        repeat (n) @(posedge clk_i);
        chk("idle_starts", 32'h0, starts.size());
    endtask : quiet
    // Power level is launched at the write edge; look one edge later
    task pwr_chk(input string nm, input logic e);
        @(posedge clk_i);
        chk(nm, {31'h0, e}, {31'h0, pwr});
    endtask : pwr_chk

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, 4'h2, 32'hFFFFFFFF);
        wb(1'b0, adc_pkg::OFS_MODE, 32'h0);
        chk("mode_rst", 32'h0, rd);
        wb(1'b0, adc_pkg::OFS_CHSEL, 32'h0);
        chk("chsel_rst", 32'h0, rd);
        wb(1'b0, adc_pkg::OFS_RESULT, 32'h0);
        chk("result_rst", 32'h0, rd);
        wb(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, rd);
        wb(1'b1, adc_pkg::OFS_MODE, ST);
        wb(1'b0, adc_pkg::OFS_MODE, 32'h0);
        chk("start_unpowered", 32'h0, rd);
        for (int os = 0; os < 2; os++) begin
            wb(1'b1, adc_pkg::OFS_MODE, PW | SC | (os ? OS : 32'h0));
            pwr_chk("power_on", 1'b1);
            wb(1'b0, adc_pkg::OFS_STATUS, 32'h0);
            chk("standby", 32'h2, rd & 32'h3);
            pulse();
            quiet(20);
            repeat (adc_pkg::STAB_WAIT_CYCLES) @(posedge clk_i);
            wb(1'b1, adc_pkg::OFS_MODE, PW | SC | ST | (os ? OS : 32'h0));
            quiet(20);
            seed = lfsr(seed);
            c = seed[2:0];
            wb(1'b1, adc_pkg::OFS_CHSEL, {29'h0, c});
            starts.delete();
            n0 = nirq;
            pulse();
            for (int i = 0; i < 4; i++) begin
                get_start(ch);
                chk("scan_ch", {29'h0, c + 3'(i)}, {29'h0, ch});
            end
            if (os) begin
                quiet(60);
                chk("irqs", 32'h4, nirq - n0);
                wb(1'b0, adc_pkg::OFS_RESULT, 32'h0);
                chk("result", exp_res(c + 3'h3), rd);
                wb(1'b0, adc_pkg::OFS_MODE, 32'h0);
                chk("start_kept", ST, rd & ST);
            end else begin
                get_start(ch);
                chk("wrap", {29'h0, c}, {29'h0, ch});
                n0 = nirq;
                pulse();
                get_start(ch);
                chk("trig_restart", {29'h0, c}, {29'h0, ch});
                chk("no_irq_abort", n0, nirq);
                wb(1'b1, adc_pkg::OFS_MODE, PW | SC | ST);
                get_start(ch);
                chk("start_restart", {29'h0, c}, {29'h0, ch});
                wb(1'b1, adc_pkg::OFS_CHSEL, {29'h0, ~c});
                get_start(ch);
                chk("chsel_restart", {29'h0, ~c}, {29'h0, ch});
                wb(1'b1, adc_pkg::OFS_MODE, PW | SC);
                quiet(60);
                chk("kept_power", 32'h1, {31'h0, pwr});
            end
            wb(1'b1, adc_pkg::OFS_MODE, 32'h0);
            pwr_chk("power_off", 1'b0);
        end
        for (int os = 0; os < 2; os++) begin
            seed = lfsr(seed);
            c = seed[2:0];
            wb(1'b1, adc_pkg::OFS_CHSEL, {29'h0, c});
            wb(1'b1, adc_pkg::OFS_MODE, PW | WT | (os ? OS : 32'h0));
            pwr_chk("wait_standby_pwr", 1'b0);
            quiet(10);
            pulse();
            get_start(ch);
            chk("sel_ch", {29'h0, c}, {29'h0, ch});
            n0 = nirq;
            repeat (2) @(posedge clk_i);
            chk("powered", 32'h1, {31'h0, pwr});
            wb(1'b0, adc_pkg::OFS_MODE, 32'h0);
            chk("auto_start", ST, rd & ST);
            if (os) begin
                quiet(60);
                chk("one_irq", 32'h1, nirq - n0);
                wb(1'b0, adc_pkg::OFS_MODE, 32'h0);
                chk("auto_clear", 32'h0, rd & ST);
                chk("auto_off", 32'h0, {31'h0, pwr});
                wb(1'b0, adc_pkg::OFS_RESULT, 32'h0);
                chk("sel_result", exp_res(c), rd);
            end else begin
                get_start(ch);
                chk("repeat", {29'h0, c}, {29'h0, ch});
                wb(1'b1, adc_pkg::OFS_CHSEL, {29'h0, ~c});
                get_start(ch);
                chk("sel_new", {29'h0, ~c}, {29'h0, ch});
                pulse();
                get_start(ch);
                chk("sel_restart", {29'h0, ~c}, {29'h0, ch});
                wb(1'b1, adc_pkg::OFS_MODE, PW | WT);
                pwr_chk("clear_off", 1'b0);
                quiet(60);
                wb(1'b1, adc_pkg::OFS_MODE, 32'h0);
                pulse();
                quiet(20);
            end
            wb(1'b1, adc_pkg::OFS_MODE, 32'h0);
        end
        finish_test();
    end
endmodule : adc_hw_trigger_sequencer_tb_top
